// >>> rtl/ctz_cfg.svh
// offsets, field positions, reset values of the temperature-zone registers
// assumes inclusion by bare name from package and module files
`ifndef CTZ_CFG_SVH
`define CTZ_CFG_SVH
`define CTZ_ADDR_W          8
`define CTZ_COLD_OFFSET     8'h05
`define CTZ_COOL_OFFSET     8'h06
`define CTZ_COLD_RESET      8'h20
`define CTZ_COOL_RESET      8'h4B
`define CTZ_THR_MSB         7
`define CTZ_THR_LSB         5
`define CTZ_VOLT_MSB        4
`define CTZ_VOLT_LSB        3
`define CTZ_CUR_MSB         2
`define CTZ_CUR_LSB         0
`define CTZ_CUR_RESERVED    3'h7
`endif

// >>> rtl/ctz_pkg.sv
// types shared by the temperature-zone register bank
// assumes ctz_cfg.svh is on the include path
`include "ctz_cfg.svh"
package ctz_pkg;
    // one zone register split into its fields
    typedef struct packed {
        logic [2:0] threshold;
        logic [1:0] term_voltage;
        logic [2:0] current_fraction;
    } ctz_zone_s;

    // decoded settings for one zone, in physical units
    typedef struct packed {
        logic signed [7:0] threshold_degc;
        logic [11:0]       term_voltage_mv;
        logic [9:0]        current_permille;
        logic              current_reserved;
    } ctz_decoded_s;

    // whole module state; decoded and applied settings are registered too
    typedef struct packed {
        ctz_zone_s    cold;
        ctz_zone_s    cool;
        logic [7:0]   rd_data;
        ctz_decoded_s cold_cfg;
        ctz_decoded_s cool_cfg;
        logic         zone_active;
        logic [11:0]  term_voltage_mv;
        logic [9:0]   current_permille;
    } ctz_state_s;
endpackage : ctz_pkg

// >>> rtl/ctz_zone_regs.sv
// two read/write zone registers and their decoded charger settings
// assumes a synchronous host port with read data one cycle after the strobe
// Functional notes
// R1: first threshold code selects -10 to 60 C
// R2: second threshold decoded with same temperature map
// R3: cold zone voltage code 2.0 to 2.1 V
// R4: cool zone voltage uses same four codes
// R5: cold zone current code gives percent steps
// R6: cool zone current uses same percent steps
// R7: apply zone settings only inside zone; 111 reserved
`timescale 1ns/1ps
`include "ctz_cfg.svh"
module ctz_zone_regs (
    input  wire logic                       clock_i,
    input  wire logic                       rst_i,
    input  wire logic [`CTZ_ADDR_W-1:0]     addr_i,
    input  wire logic [7:0]                 wr_data_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    input  wire logic signed [7:0]          temp_degc_i,
    output logic [7:0]                      rd_data_o,
    output ctz_pkg::ctz_decoded_s           cold_cfg_o,
    output ctz_pkg::ctz_decoded_s           cool_cfg_o,
    output logic                            zone_active_o,
    output logic [11:0]                     term_voltage_mv_o,
    output logic [9:0]                      current_permille_o
);
    ctz_pkg::ctz_state_s state;
    ctz_pkg::ctz_state_s next_state;
    // zone select helpers, written only by the next-state process
    logic signed [7:0]   cold_limit;
    logic signed [7:0]   cool_limit;
    logic                in_cold;
    logic                in_cool;

    // shared temperature map for both threshold fields
    function automatic logic signed [7:0] thr_decode(input logic [2:0] code);
        unique case (code)
            3'h0: thr_decode = -8'sd10;
            3'h1: thr_decode = 8'sd0;
            3'h2: thr_decode = 8'sd10;
            3'h3: thr_decode = 8'sd15;
            3'h4: thr_decode = 8'sd40;
            3'h5: thr_decode = 8'sd45;
            3'h6: thr_decode = 8'sd50;
            3'h7: thr_decode = 8'sd60;
        endcase
    endfunction : thr_decode

    // termination feedback voltage in millivolts
    function automatic logic [11:0] volt_decode(input logic [1:0] code);
        unique case (code)
            2'h0: volt_decode = 12'h7D0;
            2'h1: volt_decode = 12'h802;
            2'h2: volt_decode = 12'h81B;
            2'h3: volt_decode = 12'h834;
        endcase
    endfunction : volt_decode

    // fraction in tenths of a percent; reserved code forced to zero current
    function automatic logic [9:0] cur_decode(input logic [2:0] code);
        unique case (code)
            3'h0: cur_decode = 10'h000;
            3'h1: cur_decode = 10'h0FA;
            3'h2: cur_decode = 10'h177;
            3'h3: cur_decode = 10'h1F4;
            3'h4: cur_decode = 10'h271;
            3'h5: cur_decode = 10'h2EE;
            3'h6: cur_decode = 10'h36B;
            3'h7: cur_decode = 10'h000;
        endcase
    endfunction : cur_decode

    // whole-register decode, shared by both zones and by reset
    function automatic ctz_pkg::ctz_decoded_s zone_decode(input ctz_pkg::ctz_zone_s zone);
        zone_decode.threshold_degc   = thr_decode(zone.threshold);
        zone_decode.term_voltage_mv  = volt_decode(zone.term_voltage);
        zone_decode.current_permille = cur_decode(zone.current_fraction);
        zone_decode.current_reserved = zone.current_fraction == `CTZ_CUR_RESERVED; // [R7]
    endfunction : zone_decode

    // register writes and read mux
    always_comb
    begin
        next_state = state;
        next_state.rd_data = 8'h00;
        if (wr_i && addr_i == `CTZ_COLD_OFFSET)
        begin
            next_state.cold = wr_data_i;
        end
        if (wr_i && addr_i == `CTZ_COOL_OFFSET)
        begin
            next_state.cool = wr_data_i;
        end
        if (rd_i)
        begin
            // unmapped addresses read zero
            if (addr_i == `CTZ_COLD_OFFSET)
            begin
                next_state.rd_data = state.cold;
            end
            else if (addr_i == `CTZ_COOL_OFFSET)
            begin
                next_state.rd_data = state.cool;
            end
        end

        // decoded settings follow the register values taken at this edge
        next_state.cold_cfg = zone_decode(next_state.cold);          // [R1] [R3] [R5]
        next_state.cool_cfg = zone_decode(next_state.cool);          // [R2] [R4] [R6]

        // zone select; at or above both thresholds this bank has no say
        cold_limit = next_state.cold_cfg.threshold_degc;
        cool_limit = next_state.cool_cfg.threshold_degc;
        in_cold    = temp_degc_i < cold_limit;                       // [R7]
        in_cool    = !in_cold && (temp_degc_i < cool_limit);         // [R7]
        next_state.zone_active      = in_cold || in_cool;            // [R7]
        next_state.term_voltage_mv  = 12'h000;
        next_state.current_permille = 10'h000;
        if (in_cold)
        begin
            next_state.term_voltage_mv  = next_state.cold_cfg.term_voltage_mv;  // [R7]
            next_state.current_permille = next_state.cold_cfg.current_permille; // [R7]
        end
        else if (in_cool)
        begin
            next_state.term_voltage_mv  = next_state.cool_cfg.term_voltage_mv;  // [R7]
            next_state.current_permille = next_state.cool_cfg.current_permille; // [R7]
        end

        // reset wins over any strobe or temperature in the same cycle
        if (rst_i)
        begin
            next_state          = '0;
            next_state.cold     = `CTZ_COLD_RESET;
            next_state.cool     = `CTZ_COOL_RESET;
            next_state.cold_cfg = zone_decode(`CTZ_COLD_RESET);
            next_state.cool_cfg = zone_decode(`CTZ_COOL_RESET);
        end
    end

    // one register stage for the whole state; reset is folded in above
    always_ff @(posedge clock_i)
    begin
        state <= next_state;
    end

    assign rd_data_o = state.rd_data;

    // data outputs straight from flops, so the charger sees no decode glitches
    assign cold_cfg_o         = state.cold_cfg;
    assign cool_cfg_o         = state.cool_cfg;
    assign zone_active_o      = state.zone_active;
    assign term_voltage_mv_o  = state.term_voltage_mv;
    assign current_permille_o = state.current_permille;

    // register access seen from the host port
    a_read_cold: assert property (@(posedge clock_i) disable iff (rst_i)  // [R1]
        rd_i && addr_i == `CTZ_COLD_OFFSET |=> rd_data_o == $past(state.cold))
        else $error("cold register read mismatch");
    a_read_cool: assert property (@(posedge clock_i) disable iff (rst_i)  // [R2]
        rd_i && addr_i == `CTZ_COOL_OFFSET |=> rd_data_o == $past(state.cool))
        else $error("cool register read mismatch");
    a_write_cold: assert property (@(posedge clock_i) disable iff (rst_i)  // [R3]
        wr_i && addr_i == `CTZ_COLD_OFFSET |=> state.cold == $past(wr_data_i))
        else $error("cold register write lost");
    a_write_cool: assert property (@(posedge clock_i) disable iff (rst_i)  // [R4]
        wr_i && addr_i == `CTZ_COOL_OFFSET |=> state.cool == $past(wr_data_i))
        else $error("cool register write lost");

    // zone application, one edge after the temperature is sampled
    a_cold_current: assert property (@(posedge clock_i) disable iff (rst_i)  // [R5]
        !wr_i && temp_degc_i < $signed(cold_cfg_o.threshold_degc) |=>
            zone_active_o && current_permille_o == $past(cold_cfg_o.current_permille)
            && term_voltage_mv_o == $past(cold_cfg_o.term_voltage_mv))
        else $error("cold zone current not applied");
    a_cool_current: assert property (@(posedge clock_i) disable iff (rst_i)  // [R6]
        !wr_i && temp_degc_i >= $signed(cold_cfg_o.threshold_degc)
            && temp_degc_i < $signed(cool_cfg_o.threshold_degc) |=>
            zone_active_o && current_permille_o == $past(cool_cfg_o.current_permille)
            && term_voltage_mv_o == $past(cool_cfg_o.term_voltage_mv))
        else $error("cool zone current not applied");
    a_above_zones: assert property (@(posedge clock_i) disable iff (rst_i)  // [R7]
        !wr_i && temp_degc_i >= $signed(cold_cfg_o.threshold_degc)
            && temp_degc_i >= $signed(cool_cfg_o.threshold_degc) |=>
            !zone_active_o)
        else $error("zone active above both thresholds");
    a_outside_zone: assert property (@(posedge clock_i) disable iff (rst_i)  // [R7]
        !zone_active_o |-> term_voltage_mv_o == 12'h000 && current_permille_o == 10'h000)
        else $error("setting applied outside zones");
    a_reserved_zero: assert property (@(posedge clock_i) disable iff (rst_i)  // [R7]
        cold_cfg_o.current_reserved |-> cold_cfg_o.current_permille == 10'h000)
        else $error("reserved current code not zero");
    a_cool_reserved: assert property (@(posedge clock_i) disable iff (rst_i)  // [R7]
        cool_cfg_o.current_reserved |-> cool_cfg_o.current_permille == 10'h000)
        else $error("cool reserved current code not zero");

    // field maps at chosen codes, one edge after the write
    a_cold_thr_low: assert property (@(posedge clock_i) disable iff (rst_i)  // [R1]
        wr_i && addr_i == `CTZ_COLD_OFFSET && wr_data_i[`CTZ_THR_MSB:`CTZ_THR_LSB] == 3'h0
            |=> cold_cfg_o.threshold_degc == -8'sd10)
        else $error("cold threshold low code wrong");
    a_cold_thr_top: assert property (@(posedge clock_i) disable iff (rst_i)  // [R1]
        wr_i && addr_i == `CTZ_COLD_OFFSET && wr_data_i[`CTZ_THR_MSB:`CTZ_THR_LSB] == 3'h7
            |=> cold_cfg_o.threshold_degc == 8'sd60)
        else $error("cold threshold top code wrong");
    a_cool_thr_zero: assert property (@(posedge clock_i) disable iff (rst_i)  // [R2]
        wr_i && addr_i == `CTZ_COOL_OFFSET && wr_data_i[`CTZ_THR_MSB:`CTZ_THR_LSB] == 3'h1
            |=> cool_cfg_o.threshold_degc == 8'sd0)
        else $error("cool threshold zero code wrong");
    a_cool_thr_fifty: assert property (@(posedge clock_i) disable iff (rst_i)  // [R2]
        wr_i && addr_i == `CTZ_COOL_OFFSET && wr_data_i[`CTZ_THR_MSB:`CTZ_THR_LSB] == 3'h6
            |=> cool_cfg_o.threshold_degc == 8'sd50)
        else $error("cool threshold fifty code wrong");
    a_cold_volt_low: assert property (@(posedge clock_i) disable iff (rst_i)  // [R3]
        wr_i && addr_i == `CTZ_COLD_OFFSET && wr_data_i[`CTZ_VOLT_MSB:`CTZ_VOLT_LSB] == 2'h0
            |=> cold_cfg_o.term_voltage_mv == 12'h7D0)
        else $error("cold voltage low code wrong");
    a_cool_volt_top: assert property (@(posedge clock_i) disable iff (rst_i)  // [R4]
        wr_i && addr_i == `CTZ_COOL_OFFSET && wr_data_i[`CTZ_VOLT_MSB:`CTZ_VOLT_LSB] == 2'h3
            |=> cool_cfg_o.term_voltage_mv == 12'h834)
        else $error("cool voltage top code wrong");
    a_cold_cur_mid: assert property (@(posedge clock_i) disable iff (rst_i)  // [R5]
        wr_i && addr_i == `CTZ_COLD_OFFSET && wr_data_i[`CTZ_CUR_MSB:`CTZ_CUR_LSB] == 3'h4
            |=> cold_cfg_o.current_permille == 10'h271)
        else $error("cold current mid code wrong");
    a_cool_cur_top: assert property (@(posedge clock_i) disable iff (rst_i)  // [R6]
        wr_i && addr_i == `CTZ_COOL_OFFSET && wr_data_i[`CTZ_CUR_MSB:`CTZ_CUR_LSB] == 3'h6
            |=> cool_cfg_o.current_permille == 10'h36B)
        else $error("cool current top code wrong");
endmodule : ctz_zone_regs

// >>> verification/ctz_zone_regs_tb.sv
// self-checking bench for the temperature-zone register bank
// assumes rtl/ctz_cfg.svh on the include path; drives every port itself
`timescale 1ns/1ps
module ctz_zone_regs_tb;
    logic                  clock_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic [7:0]            addr_i = 8'h00;
    logic [7:0]            wr_data_i = 8'h00;
    logic                  wr_i = 1'b0;
    logic                  rd_i = 1'b0;
    logic signed [7:0]     temp_degc_i = 8'sh00;
    logic [7:0]            rd_data_o;
    ctz_pkg::ctz_decoded_s cold_cfg_o;
    ctz_pkg::ctz_decoded_s cool_cfg_o;
    logic                  zone_active_o;
    logic [11:0]           term_voltage_mv_o;
    logic [9:0]            current_permille_o;
    int                    err_count = 0;
    int                    comparisons = 0;
    int                    thr[8] = '{-10, 0, 10, 15, 40, 45, 50, 60};
    int                    mv[4] = '{2000, 2050, 2075, 2100};
    int                    pm[8] = '{0, 250, 375, 500, 625, 750, 875, 0};

    ctz_zone_regs dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .temp_degc_i(temp_degc_i),
        .rd_data_o(rd_data_o), .cold_cfg_o(cold_cfg_o), .cool_cfg_o(cool_cfg_o),
        .zone_active_o(zone_active_o), .term_voltage_mv_o(term_voltage_mv_o),
        .current_permille_o(current_permille_o));

    // 40 ns period clock
    always #20 clock_i = ~clock_i;

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    // one-cycle strobes, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk("rd_data_o", rd_data_o, exp);
    endtask : rd

    // reset values, unmapped place ignored, data stands one cycle only
    task automatic t_regs;
        rd(8'h05, 8'h20);
        rd(8'h06, 8'h4B);
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h00);
        wr(8'h05, 8'hA5);
        rd(8'h05, 8'hA5);
        @(posedge clock_i);
        #1 chk("rd_data_o idle", rd_data_o, 8'h00);
        $display("test regs done");
    endtask : t_regs

    // every code of every field, both zones
    task automatic t_decode;
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h05, {i[2:0], i[1:0], i[2:0]});
            wr(8'h06, {3'(7 - i), i[1:0], 3'(7 - i)});
            chk("cold thr", 32'(cold_cfg_o.threshold_degc), 32'(thr[i]));
            chk("cool thr", 32'(cool_cfg_o.threshold_degc), 32'(thr[7 - i]));
            chk("cold mv", cold_cfg_o.term_voltage_mv, mv[i % 4]);
            chk("cool mv", cool_cfg_o.term_voltage_mv, mv[i % 4]);
            chk("cold pm", cold_cfg_o.current_permille, pm[i]);
            chk("cool pm", cool_cfg_o.current_permille, pm[7 - i]);
            chk("cold rsv", cold_cfg_o.current_reserved, i == 7);
            chk("cool rsv", cool_cfg_o.current_reserved, i == 0);
        end
        $display("test decode done");
    endtask : t_decode

    // temperature driven at an edge; the applied zone is registered one edge later
    task automatic at_temp(input logic signed [7:0] t);
        @(posedge clock_i);
        temp_degc_i <= t;
        @(posedge clock_i);
        #1;
    endtask : at_temp

    // zone edges: cold below 0 C, cool from 0 C up to 39 C, none at 40 C
    task automatic t_zone;
        wr(8'h05, 8'h2D);
        wr(8'h06, 8'h9A);
        at_temp(-8'sd5);
        chk("cold v", {zone_active_o, term_voltage_mv_o, current_permille_o},
            {1'b1, 12'd2050, 10'd750});
        at_temp(8'sd0);
        chk("cool lo", {zone_active_o, term_voltage_mv_o, current_permille_o},
            {1'b1, 12'd2100, 10'd375});
        at_temp(8'sd39);
        chk("cool hi", {zone_active_o, term_voltage_mv_o, current_permille_o},
            {1'b1, 12'd2100, 10'd375});
        at_temp(8'sd40);
        chk("outside", {zone_active_o, term_voltage_mv_o, current_permille_o}, 0);
        // reserved current code applies no current inside its zone
        wr(8'h05, 8'h27);
        at_temp(-8'sd5);
        chk("reserved", {zone_active_o, term_voltage_mv_o, current_permille_o},
            {1'b1, 12'd2000, 10'd0});
        // second threshold below the first leaves the cool zone empty
        wr(8'h06, 8'h1A);
        at_temp(8'sd5);
        chk("cool empty", {zone_active_o, term_voltage_mv_o, current_permille_o}, 0);
        $display("test zone done");
    endtask : t_zone

    // reset in mid-run restores both registers and clears the applied zone
    task automatic t_reset;
        wr(8'h05, 8'hFF);
        wr(8'h06, 8'h00);
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        #1 chk("zone in reset", zone_active_o, 1'b0);
        chk("cold thr rst", 32'(cold_cfg_o.threshold_degc), 32'(thr[1]));
        chk("cool mv rst", cool_cfg_o.term_voltage_mv, mv[1]);
        chk("cool pm rst", cool_cfg_o.current_permille, pm[3]);
        rd(8'h05, 8'h20);
        rd(8'h06, 8'h4B);
        $display("test reset done");
    endtask : t_reset

    // hang guard and main sequence
    initial
    begin
        #200000 err_count++;
        give_verdict();
    end

    initial
    begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        t_regs();
        t_decode();
        t_zone();
        t_reset();
        give_verdict();
    end
endmodule : ctz_zone_regs_tb
